// >>> test_uart_extra_feature_control.sv
/* Self-checking bench for the extra-feature control block.
   Assumes the core model on the far side and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module test_uart_extra_feature_control;
  logic clk = 0, sys_rst = 1, regWrStb = 0, regRdStb = 0, go = 0, rdSeen = 0;
  logic coreRtsN = 1, remoteStopped = 0, localStopSent = 0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00, regRdData, r;
  logic [1:0] flowState = 2'h0;
  logic txCharQueued, shifterBusy, txLoadEnable, rtsN, irdaQuarterPulse, rxDisable, nineBitMode;
  logic [31:0] seed = 32'd98806;
  logic [7:0] q[$];
  int fail_count = 0, cmp_count = 0;
  uart_extra_feature_control uut (.*);
  uart_core_model far (.*);
  always #25 clk = ~clk;
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task tick(input int n); repeat (n) @(posedge clk); #1; endtask
  task send; go <= 1; @(posedge clk); go <= 0; endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk); regAddr <= a; regWrData <= d; regWrStb <= 1;
    @(posedge clk); regWrStb <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    q.push_back(e);
    @(posedge clk); regAddr <= a; regRdStb <= 1;
    @(posedge clk); regRdStb <= 0;
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rdSeen) chk(regRdData, q.pop_front());
    rdSeen <= regRdStb;
  end
  // The span allows more than twenty times the expected run before giving up.
  initial begin #200000; fail_count++; stop_test; end
  initial begin
    repeat (10) @(posedge clk); sys_rst <= 0;
    rd(4'hF, 8'h00);
    rd(4'h2, 8'h00);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      wr(4'hF, r);
      rd(4'hF, r & 8'hB7);
      tick(1);
      chk({irdaQuarterPulse, rxDisable, nineBitMode}, {r[7], r[1], r[0]});
    end
    wr(4'hD, 8'h5A); wr(4'h3, 8'hBF);
    rd(4'hD, 8'h00);
    wr(4'hD, 8'h5A);
    rd(4'hD, 8'h5A);
    wr(4'h7, 8'h04);
    rd(4'h7, 8'h04);
    rd(4'hF, 8'h00);
    for (int i = 0; i < 4; i++) begin
      r = rnd(); flowState <= i[1:0]; remoteStopped <= r[0]; localStopSent <= r[1];
      tick(2);
      rd(4'h2, {2'h0, i[1:0], 2'h0, r[1], r[0]});
    end
    wr(4'hD, 8'h00);
    rd(4'h7, 8'h00);
    wr(4'hD, 8'h5A); wr(4'h7, 8'h00); wr(4'h3, 8'h00);
    rd(4'h2, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(4'hF, {2'h0, p[0], 5'h10});
      send; tick(3);
      chk(rtsN, p[0]);
      repeat (40) if (shifterBusy) tick(1);
      tick(3);
      chk(rtsN, !p[0]);
    end
    @(posedge clk); coreRtsN <= 0; wr(4'hF, 8'h00); tick(3);
    chk(rtsN, 1'b0);
    wr(4'hF, 8'h04); send; tick(12);
    chk({txLoadEnable, shifterBusy}, 2'h0);
    wr(4'hF, 8'h00); tick(3);
    chk(shifterBusy, 1'b1);
    tick(20); stop_test;
  end
endmodule
`default_nettype wire

// >>> uart_core_model.sv
/* Model of the UART core beside the block: queues one character on go.
   Assumes the bench pulses go for one cycle. */
`timescale 1ns/1ps
`default_nettype none
module uart_core_model (
  input wire logic  clk,
  input wire logic  sys_rst,
  input wire logic  go,
  input wire logic  txLoadEnable,
  output var logic  txCharQueued,
  output wire logic shifterBusy
);
  logic [3:0] cnt_r;
  assign shifterBusy = cnt_r != 4'h0;
  // A started character always runs to its end; only new loads wait.
  always @(posedge clk) begin
    if (sys_rst) begin
      txCharQueued <= 1'b0;
      cnt_r <= 4'h0;
    end else if (go) txCharQueued <= 1'b1;
    else if (txCharQueued && txLoadEnable && !shifterBusy) begin
      txCharQueued <= 1'b0;
      cnt_r <= 4'hA;
    end else if (shifterBusy) cnt_r <= cnt_r - 4'h1;
  end
endmodule
`default_nettype wire

// >>> uart_efc_map.vh
/*
  Register offsets, field positions, key values and reset values for the UART
  extra-feature control block. Assumes a 4-bit byte-wide register port.
*/
`ifndef UART_EFC_MAP_VH
`define UART_EFC_MAP_VH

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define OFS_ADV_STATUS   4'h2
`define OFS_LINE_CTRL    4'h3
`define OFS_SPECIAL_FUNC 4'h7
`define OFS_ACCESS_KEY   4'hD
`define OFS_EXTRA_CTRL   4'hF

// ----------------------------------------------------------------------------
// Values and fields
// ----------------------------------------------------------------------------
`define LINE_CTRL_UNLOCK 8'hBF
`define ACCESS_KEY_VALUE 8'h5A
`define RESET_BYTE       8'h00
`define EXTRA_CTRL_MASK  8'hB7
`define SFR_ACCESS_BIT   2
`define EFC_IRDA_BIT     7
`define EFC_POL_BIT      5
`define EFC_AUTODIR_BIT  4
`define EFC_TXDIS_BIT    2
`define EFC_RXDIS_BIT    1
`define EFC_NINEBIT_BIT  0

`endif

// >>> uart_efc_sva.sv
/* Checker for the extra-feature control block, seeing its ports only.
   Assumes the default widths of four address and eight data bits. */
`timescale 1ns/1ps
`default_nettype none
module uart_efc_sva (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrStb,
  input wire logic       regRdStb,
  input wire logic [7:0] regRdData,
  input wire logic [1:0] flowState,
  input wire logic       remoteStopped,
  input wire logic       localStopSent,
  input wire logic       txLoadEnable,
  input wire logic       irdaQuarterPulse,
  input wire logic       rxDisable,
  input wire logic       nineBitMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  rd_idle_zero_a: assert property (!regRdStb |=> regRdData == 8'h00)
    else $error("read data not idle");
  irda_cause_a: assert property ($changed(irdaQuarterPulse) |-> $past(regWrStb, 2)
    && $past(regAddr, 2) == 4'hF && irdaQuarterPulse == $past(regWrData[7], 2)) else $error("irda moved");
  rxdis_cause_a: assert property ($changed(rxDisable) |-> $past(regWrStb, 2)
    && $past(regAddr, 2) == 4'hF && rxDisable == $past(regWrData[1], 2)) else $error("rx disable moved");
  nine_cause_a: assert property ($changed(nineBitMode) |-> $past(regWrStb, 2)
    && $past(regAddr, 2) == 4'hF && nineBitMode == $past(regWrData[0], 2)) else $error("nine bit moved");
  load_stop_a: assert property ($fell(txLoadEnable) |-> $past(regWrStb, 2)
    && $past(regWrData[2], 2)) else $error("load stopped unasked");
  stat_rsv_a: assert property ($past(regRdStb) && $past(regAddr) == 4'h2
    |-> regRdData[7:6] == 2'h0 && regRdData[3:2] == 2'h0) else $error("status reserved set");
  ctrl_rsv_a: assert property ($past(regRdStb) && $past(regAddr) == 4'hF
    |-> regRdData[6] == 1'b0 && regRdData[3] == 1'b0) else $error("control reserved set");
  stat_value_a: assert property ($past(regRdStb) && $past(regAddr) == 4'h2 && regRdData != 8'h00
    |-> regRdData[5:0] == {$past(flowState, 2), 2'h0, $past(localStopSent, 2), $past(remoteStopped, 2)})
    else $error("status value wrong");
endmodule
bind uart_extra_feature_control uart_efc_sva chk (.*);
`default_nettype wire

// >>> uart_extra_feature_control.v
/*
  Extra-feature control and advanced flow status for one UART channel.
  Assumes the host bridge presents a plain register port (address, write
  strobe, read strobe, data) and that the UART core reports shifter activity
  and software flow state as levels synchronous to clk.
*/
// Local design decision: the address-and-strobe port.
`include "uart_efc_map.vh"
`timescale 1ns/1ps
`default_nettype none

module uart_extra_feature_control #(
  parameter ADDR_W = 4,
  parameter DATA_W = 8
) (
  input  wire              clk,
  input  wire              sys_rst,
  input  wire [ADDR_W-1:0] regAddr,
  input  wire [DATA_W-1:0] regWrData,
  input  wire              regWrStb,
  input  wire              regRdStb,
  output reg  [DATA_W-1:0] regRdData,
  input  wire              txCharQueued,
  input  wire              shifterBusy,
  input  wire              coreRtsN,
  input  wire [1:0]        flowState,
  input  wire              remoteStopped,
  input  wire              localStopSent,
  output reg               txLoadEnable,
  output reg               rtsN,
  output reg               irdaQuarterPulse,
  output reg               rxDisable,
  output reg               nineBitMode
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [7:0] lineCtrl_r;
  reg [7:0] specialFunc_r;
  reg [7:0] accessKey_r;
  reg [7:0] extraCtrl_r;
  reg [7:0] advStatus_r;
  reg       txActive_r;

  wire lcrUnlocked = (lineCtrl_r == `LINE_CTRL_UNLOCK);
  wire keyPresent  = (accessKey_r == `ACCESS_KEY_VALUE);
  wire altMap      = specialFunc_r[`SFR_ACCESS_BIT];

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  // Returns a one-hot select: 0 line control, 1 special function, 2 key,
  // 3 extra control, 4 advanced status. Used by both reads and writes so the
  // two paths can never disagree on what is mapped.
  function [4:0] decode;
    input [ADDR_W-1:0] a;
    input              unl;
    input              key;
    input              alt;
    begin
      decode    = 5'h00;
      decode[0] = (a == `OFS_LINE_CTRL);
      decode[1] = (a == `OFS_SPECIAL_FUNC) && unl && key;
      decode[2] = (a == `OFS_ACCESS_KEY) && unl;
      decode[3] = (a == `OFS_EXTRA_CTRL) && !alt;
      decode[4] = (a == `OFS_ADV_STATUS) && unl && alt;
    end
  endfunction

  wire [4:0] sel = decode(regAddr, lcrUnlocked, keyPresent, altMap);

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      lineCtrl_r    <= `RESET_BYTE;
      specialFunc_r <= `RESET_BYTE;
      accessKey_r   <= `RESET_BYTE;
      extraCtrl_r   <= `RESET_BYTE;
    end else if (regWrStb) begin
      if (sel[0]) begin
        lineCtrl_r <= regWrData;
      end
      if (sel[1]) begin
        specialFunc_r <= regWrData;
      end
      if (sel[2]) begin
        accessKey_r <= regWrData;
      end
      if (sel[3]) begin
        // Reserved bits 6 and 3 stay zero.
        extraCtrl_r <= regWrData & `EXTRA_CTRL_MASK;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  // Data stands only in the cycle after the strobe; unmapped reads return zero.
  always @(posedge clk) begin
    if (sys_rst) begin
      regRdData <= `RESET_BYTE;
    end else if (regRdStb) begin
      case (sel)
        5'h01:   regRdData <= lineCtrl_r;
        5'h02:   regRdData <= specialFunc_r;
        5'h04:   regRdData <= accessKey_r;
        5'h08:   regRdData <= extraCtrl_r;
        5'h10:   regRdData <= advStatus_r;
        default: regRdData <= `RESET_BYTE;
      endcase
    end else begin
      regRdData <= `RESET_BYTE;
    end
  end

  // --------------------------------------------------------------------------
  // Advanced flow status
  // --------------------------------------------------------------------------
  // Sampled each cycle so a read sees state one cycle old at most.
  always @(posedge clk) begin
    if (sys_rst) begin
      advStatus_r <= `RESET_BYTE;
    end else begin
      advStatus_r <= {2'b00, flowState, 2'b00,
                      localStopSent,
                      remoteStopped};
    end
  end

  // --------------------------------------------------------------------------
  // Control outputs
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      irdaQuarterPulse <= 1'b0;
      rxDisable        <= 1'b0;
      nineBitMode      <= 1'b0;
      txLoadEnable     <= 1'b0;
    end else begin
      irdaQuarterPulse <= extraCtrl_r[`EFC_IRDA_BIT];
      rxDisable        <= extraCtrl_r[`EFC_RXDIS_BIT];
      nineBitMode      <= extraCtrl_r[`EFC_NINEBIT_BIT];
      // Only new loads are blocked, so a character already in the shifter
      // always completes and no half frame reaches the line.
      txLoadEnable     <= !extraCtrl_r[`EFC_TXDIS_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // RS-485 direction
  // --------------------------------------------------------------------------
  // Transmitting spans queued characters and the shifter, so the driver stays
  // on between back-to-back characters.
  always @(posedge clk) begin
    if (sys_rst) begin
      txActive_r <= 1'b0;
      rtsN       <= 1'b1;
    end else begin
      txActive_r <= shifterBusy ||
                    (txCharQueued && !extraCtrl_r[`EFC_TXDIS_BIT]);
      if (extraCtrl_r[`EFC_AUTODIR_BIT]) begin
        rtsN <= txActive_r ? extraCtrl_r[`EFC_POL_BIT]
                           : !extraCtrl_r[`EFC_POL_BIT];
      end else begin
        rtsN <= coreRtsN;
      end
    end
  end

endmodule

`default_nettype wire
